/* File: hw/lseh_pkg.sv */
// Purpose: shared constants and types for load-side encoder homing
// Assumes: 32-bit signed load-side position, 40 MHz ref_clk
// Notes:   method codes follow the signed homing method numbering
package lseh_pkg;
    localparam int POS_W = 32;
    localparam logic signed [7:0] METHOD_DOG       = 8'shff; // -1
    localparam logic signed [7:0] METHOD_IDX_FWD   = 8'sh22; // 34
    localparam logic signed [7:0] METHOD_IDX_REV   = 8'sh21; // 33
    localparam logic signed [7:0] METHOD_STROKE_F  = 8'shf5; // -11
    localparam logic signed [7:0] METHOD_STROKE_R  = 8'shd5; // -43
    localparam logic signed [7:0] METHOD_DATA_SET  = 8'sh23; // 35
    localparam logic signed [7:0] METHOD_NO_INDEX  = 8'sh11; // 17, limit only
    localparam logic [1:0] ENC_ABS_LINEAR = 2'h0;
    localparam logic [1:0] ENC_INC_LINEAR = 2'h1;
    localparam logic [1:0] ENC_ROTARY     = 2'h2;
    localparam logic [POS_W-1:0] POS_ZERO = 32'h00000000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SEARCH, ST_AFTER_DOG, ST_DONE, ST_ERROR
    } lseh_state_t;
endpackage

/* File: hw/lseh_grid.sv */
// Purpose: candidate home grid, one point per motor revolution from an origin
// Assumes: revolution length in load-side counts is nonzero when used
// Notes:   flags a crossing when position passes the next grid point
`timescale 1ns/1ps
module lseh_grid (
    input  wire logic                          ref_clk,
    input  wire logic                          arst_n,
    input  wire logic                          originLoad,
    input  wire logic [lseh_pkg::POS_W-1:0]    originPos,
    input  wire logic [lseh_pkg::POS_W-1:0]    revLength,
    input  wire logic                          dirReverse,
    input  wire logic [lseh_pkg::POS_W-1:0]    position,
    output logic                               crossed,
    output logic [lseh_pkg::POS_W-1:0]         crossPos
);
    typedef struct packed {
        logic                        crossed;
        logic [lseh_pkg::POS_W-1:0]  nextPoint;
        logic [lseh_pkg::POS_W-1:0]  crossPos;
    } lseh_grid_state_t;

    lseh_grid_state_t cur;
    lseh_grid_state_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.crossed = 1'b0;
        if (originLoad) begin
            next_cur.nextPoint = dirReverse ? originPos - revLength : originPos + revLength;
        end else if (!dirReverse && $signed(position) >= $signed(cur.nextPoint)) begin
            next_cur.crossed   = 1'b1;
            next_cur.crossPos  = cur.nextPoint;
            next_cur.nextPoint = cur.nextPoint + revLength;
        end else if (dirReverse && $signed(position) <= $signed(cur.nextPoint)) begin
            next_cur.crossed   = 1'b1;
            next_cur.crossPos  = cur.nextPoint;
            next_cur.nextPoint = cur.nextPoint - revLength;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign crossed  = cur.crossed;
    assign crossPos = cur.crossPos;
endmodule

/* File: hw/lseh_homing.sv */
// Purpose: home position selection from load-side encoder feedback
// Assumes: all inputs except arst_n synchronous to ref_clk; motion is driven by the controller
// Notes:   motor encoder index is not an input, it never affects the result
//
// Behaviour
// (R1) Home comes only from load-side encoder feedback; motor index ignored.
// (R2) Dog homing needs a mark or index seen before the dog releases, except with an absolute linear encoder.
// (R3) Absolute linear candidates repeat per revolution from absolute position zero.
// (R4) Absolute linear dog homing takes nearest candidate after dog turns off.
// (R5) Incremental linear candidates repeat per revolution from first mark after power-on.
// (R6) Incremental linear dog homing takes nearest candidate after dog rear edge.
// (R7) Mark in homing direction: home equals mark plus home shift distance.
// (R8) Method 33 equals method 34 with reversed direction.
// (R9) Method -43 equals method -11 with reversed direction.
// (R10) Incremental linear without mark allows only methods not using index.
// (R11) Rotary serial encoder: home sits at load-side index position.
// (R12) Controller-homing variant counts from mark after start; index output unused.
// (R13) Data set homing only after mark and index crossed, unless condition select.
// (R14) Controller changes method or jogs to opposite stroke end after errors.
// (R15) Controller starts homing in the same direction for repeatability.
// (R16) Reverse-at-stroke-end homing refused while software limit is enabled.
`timescale 1ns/1ps
module lseh_homing (
    input  wire logic                          ref_clk,
    input  wire logic                          arst_n,
    input  wire logic                          homingStart,
    input  wire logic signed [7:0]             homingMethod,
    input  wire logic [1:0]                    encoderType,
    input  wire logic                          markPresent,
    input  wire logic                          controllerVariant,
    input  wire logic                          softLimitEnable,
    input  wire logic                          homing_condition_select,
    input  wire logic [lseh_pkg::POS_W-1:0]    home_shift_distance_setting,
    input  wire logic [lseh_pkg::POS_W-1:0]    revLength,
    input  wire logic [lseh_pkg::POS_W-1:0]    loadPosition,
    input  wire logic                          loadIndex,
    input  wire logic                          proximityDog,
    output logic                               homingBusy,
    output logic                               homingDone,
    output logic                               homingError,
    output logic                               methodRefused,
    output logic [lseh_pkg::POS_W-1:0]         homePosition,
    output logic                               encoder_index_pulse_output
);
    typedef struct packed {
        lseh_pkg::lseh_state_t       state;
        logic                        dirReverse;
        logic                        isDog;
        logic                        isDataSet;
        logic                        markSinceStart;
        logic                        markSincePower;
        logic                        indexPrev;
        logic                        dogPrev;
        logic                        done;
        logic                        error;
        logic                        refused;
        logic [lseh_pkg::POS_W-1:0]  home;
    } lseh_homing_state_t;

    lseh_homing_state_t cur;
    lseh_homing_state_t next_cur;

    logic                        indexRise;
    logic                        dogFall;
    logic                        originLoad;
    logic [lseh_pkg::POS_W-1:0]  originPos;
    logic                        gridCrossed;
    logic [lseh_pkg::POS_W-1:0]  gridPos;
    logic                        methodKnown;
    logic                        usesIndex;
    logic                        reverseDir;

    assign indexRise = loadIndex && !cur.indexPrev;
    assign dogFall   = !proximityDog && cur.dogPrev;

    // ****************************************************************
    // method decode
    // ****************************************************************
    always_comb begin
        methodKnown = 1'b1;
        usesIndex   = 1'b1;
        reverseDir  = 1'b0;
        unique case (homingMethod)
            lseh_pkg::METHOD_DOG:      reverseDir = 1'b0;
            lseh_pkg::METHOD_IDX_FWD:  reverseDir = 1'b0;
            lseh_pkg::METHOD_IDX_REV:  reverseDir = 1'b1; // R8
            lseh_pkg::METHOD_STROKE_F: reverseDir = 1'b0;
            lseh_pkg::METHOD_STROKE_R: reverseDir = 1'b1; // R9
            lseh_pkg::METHOD_DATA_SET: usesIndex  = 1'b0;
            lseh_pkg::METHOD_NO_INDEX: usesIndex  = 1'b0;
            default:                   methodKnown = 1'b0;
        endcase
    end

    // ****************************************************************
    // candidate grid origin
    // ****************************************************************
    always_comb begin
        originLoad = 1'b0;
        originPos  = loadPosition;
        if (encoderType == lseh_pkg::ENC_ABS_LINEAR) begin
            originLoad = homingStart; // R3
            originPos  = lseh_pkg::POS_ZERO; // R3
        end else if (controllerVariant) begin
            originLoad = indexRise && !cur.markSinceStart && cur.state != lseh_pkg::ST_IDLE; // R12
        end else begin
            originLoad = indexRise && !cur.markSincePower; // R5
        end
    end

    lseh_grid u_grid (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .originLoad (originLoad),
        .originPos  (originPos),
        .revLength  (revLength),
        .dirReverse (cur.dirReverse),
        .position   (loadPosition),
        .crossed    (gridCrossed),
        .crossPos   (gridPos)
    );

    // ****************************************************************
    // homing sequence
    // ****************************************************************
    always_comb begin
        next_cur           = cur;
        next_cur.indexPrev = loadIndex;
        next_cur.dogPrev   = proximityDog;
        next_cur.done      = 1'b0;
        next_cur.error     = 1'b0;
        next_cur.refused   = 1'b0;
        if (indexRise) begin
            next_cur.markSincePower = 1'b1;
            next_cur.markSinceStart = 1'b1;
        end
        unique case (cur.state)
            lseh_pkg::ST_IDLE: begin
                if (homingStart) begin
                    // a mark seen on the start edge still counts
                    next_cur.markSinceStart = indexRise;
                    next_cur.dirReverse     = reverseDir;
                    next_cur.isDog          = homingMethod == lseh_pkg::METHOD_DOG;
                    next_cur.isDataSet      = homingMethod == lseh_pkg::METHOD_DATA_SET;
                    if (!methodKnown
                        || (homingMethod == lseh_pkg::METHOD_STROKE_F && softLimitEnable) // R16
                        || (homingMethod == lseh_pkg::METHOD_STROKE_R && softLimitEnable) // R16
                        || (encoderType == lseh_pkg::ENC_INC_LINEAR && !markPresent
                            && usesIndex)) begin // R10
                        next_cur.refused = 1'b1;
                    end else if (homingMethod == lseh_pkg::METHOD_DATA_SET) begin
                        if (cur.markSincePower || homing_condition_select) begin // R13
                            next_cur.home  = loadPosition;
                            next_cur.done  = 1'b1;
                            next_cur.state = lseh_pkg::ST_DONE;
                        end else begin
                            next_cur.refused = 1'b1; // R13
                        end
                    end else begin
                        next_cur.state = lseh_pkg::ST_SEARCH;
                    end
                end
            end
            lseh_pkg::ST_SEARCH: begin
                if (cur.isDog) begin
                    if (dogFall) begin
                        if (cur.markSinceStart || encoderType == lseh_pkg::ENC_ABS_LINEAR) begin
                            next_cur.state = lseh_pkg::ST_AFTER_DOG; // R2
                        end else begin
                            next_cur.error = 1'b1; // R2
                            next_cur.state = lseh_pkg::ST_ERROR;
                        end
                    end
                end else if (indexRise) begin
                    // R1 R11 home taken at load-side mark or index
                    next_cur.home  = loadPosition + home_shift_distance_setting; // R7
                    next_cur.done  = 1'b1;
                    next_cur.state = lseh_pkg::ST_DONE;
                end
            end
            lseh_pkg::ST_AFTER_DOG: begin
                if (encoderType == lseh_pkg::ENC_ROTARY) begin
                    if (indexRise) begin
                        next_cur.home  = loadPosition + home_shift_distance_setting; // R11
                        next_cur.done  = 1'b1;
                        next_cur.state = lseh_pkg::ST_DONE;
                    end
                end else if (gridCrossed) begin
                    next_cur.home  = gridPos + home_shift_distance_setting; // R4 R6
                    next_cur.done  = 1'b1;
                    next_cur.state = lseh_pkg::ST_DONE;
                end
            end
            lseh_pkg::ST_DONE,
            lseh_pkg::ST_ERROR: begin
                if (homingStart) begin
                    next_cur.state = lseh_pkg::ST_IDLE;
                end
            end
            default: next_cur.state = lseh_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign homingBusy    = cur.state == lseh_pkg::ST_SEARCH || cur.state == lseh_pkg::ST_AFTER_DOG;
    assign homingDone    = cur.done;
    assign homingError   = cur.error;
    assign methodRefused = cur.refused;
    assign homePosition  = cur.home;
    // index pulse output is not driven in the controller-homing variant
    assign encoder_index_pulse_output = cur.indexPrev && !controllerVariant; // R12
endmodule

/* File: testbench/lseh_partner.sv */
// Purpose: controller motion and load-side scale model for homing runs
// Assumes: one count per step, mark one count wide at 20, dog 30..40
// Notes:   slow mode steps every fourth cycle
`timescale 1ns/1ps
module lseh_partner (
    input  wire logic        ref_clk,
    input  wire logic        run,
    input  wire logic        rev,
    input  wire logic        slow,
    input  wire logic        load,
    input  wire logic [31:0] startPos,
    output logic [31:0]      loadPosition,
    output logic             loadIndex,
    output logic             proximityDog
);
    logic [1:0] tick = 2'h0;
    initial loadPosition = 32'h0;
    always @(posedge ref_clk) begin
        tick <= tick + 2'h1;
        if (load) begin
            loadPosition <= startPos;
        end else if (run && (!slow || tick == 2'h3)) begin
            loadPosition <= rev ? loadPosition - 32'h1 : loadPosition + 32'h1;
        end
    end
    // narrow mark so its edge does not depend on travel direction
    assign loadIndex    = loadPosition == 32'h14;
    assign proximityDog = loadPosition >= 32'h1e && loadPosition <= 32'h28;
endmodule

/* File: testbench/lseh_homing_assertions.sv */
// Purpose: port-level checks of the homing block
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   attached by bind below the module
`timescale 1ns/1ps
module lseh_homing_assertions (
    input  wire logic                       ref_clk,
    input  wire logic                       arst_n,
    input  wire logic                       homingStart,
    input  wire logic                       controllerVariant,
    input  wire logic                       loadIndex,
    input  wire logic                       homingBusy,
    input  wire logic                       homingDone,
    input  wire logic                       homingError,
    input  wire logic                       methodRefused,
    input  wire logic [lseh_pkg::POS_W-1:0] homePosition,
    input  wire logic                       encoder_index_pulse_output
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_done_pulse: assert property (homingDone |=> !homingDone)
        else $error("done pulse longer than one cycle");
    chk_err_pulse: assert property (homingError |=> !homingError)
        else $error("error pulse longer than one cycle");
    chk_err_cause: assert property (homingError |-> $past(homingBusy))
        else $error("error without a search");
    chk_one_outcome: assert property (!(homingDone && (homingError || methodRefused)))
        else $error("two outcomes at once");
    chk_refuse_cause: assert property (methodRefused |-> $past(homingStart) && !homingBusy)
        else $error("refusal without a start or while busy");
    chk_busy_start: assert property ($rose(homingBusy) |-> $past(homingStart))
        else $error("search began without a start");
    chk_home_hold: assert property (!$stable(homePosition) |-> homingDone)
        else $error("home moved without done");
    chk_idx_off: assert property (controllerVariant && $past(controllerVariant)
        |-> !encoder_index_pulse_output) else $error("index output in controller mode");
    chk_idx_echo: assert property (!controllerVariant && !$past(controllerVariant)
        && $past(arst_n) |-> encoder_index_pulse_output == $past(loadIndex))
        else $error("index echo wrong");
    cover property (homingDone);
    cover property (homingError);
    cover property (methodRefused);
endmodule
bind lseh_homing lseh_homing_assertions chk (.*);

/* File: testbench/test_load_side_encoder_homing.sv */
// Purpose: scenario bench for load-side encoder homing
// Assumes: 16 counts per revolution, shift distance 5
// Notes:   mark at 20, so index homes land on 25
`timescale 1ns/1ps
module test_load_side_encoder_homing;
    logic              ref_clk = 1'b0;
    logic              arst_n = 1'b0;
    logic              homingStart = 1'b0;
    logic signed [7:0] homingMethod = lseh_pkg::METHOD_DOG;
    logic [1:0]        encoderType = lseh_pkg::ENC_INC_LINEAR;
    logic              markPresent = 1'b1, ctrlVar = 1'b0, softLim = 1'b0, condSel = 1'b0;
    logic              run = 1'b0, rev = 1'b0, slow = 1'b0, load = 1'b0;
    logic [31:0]       startPos = 32'h0, loadPosition, homePosition;
    logic              loadIndex, proximityDog, homingBusy, homingDone, homingError;
    logic              methodRefused, idxOut;
    int                errorCnt = 0, testsRun = 0, idxSeen;
    logic signed [7:0] meth [4] = '{lseh_pkg::METHOD_STROKE_R, lseh_pkg::METHOD_STROKE_F,
                                    lseh_pkg::METHOD_IDX_FWD, 8'sh05};
    logic              sl [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic              mk [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    always #12.5 ref_clk = ~ref_clk;
    lseh_homing dut (.ref_clk(ref_clk), .arst_n(arst_n), .homingStart(homingStart),
        .homingMethod(homingMethod), .encoderType(encoderType), .markPresent(markPresent),
        .controllerVariant(ctrlVar), .softLimitEnable(softLim),
        .homing_condition_select(condSel), .home_shift_distance_setting(32'h5),
        .revLength(32'h10), .loadPosition(loadPosition), .loadIndex(loadIndex),
        .proximityDog(proximityDog), .homingBusy(homingBusy), .homingDone(homingDone),
        .homingError(homingError), .methodRefused(methodRefused),
        .homePosition(homePosition), .encoder_index_pulse_output(idxOut));
    lseh_partner far (.ref_clk(ref_clk), .run(run), .rev(rev), .slow(slow), .load(load),
        .startPos(startPos), .loadPosition(loadPosition), .loadIndex(loadIndex),
        .proximityDog(proximityDog));
    // ****************************************
    // checking and run control
    // ****************************************
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic place(logic [31:0] p, logic r, logic s);
        @(negedge ref_clk);
        load = 1'b1; startPos = p; rev = r; slow = s;
        @(negedge ref_clk);
        load = 1'b0; run = 1'b1;
    endtask
    // outcome is {done, error, refused}; all ones as home means the current load position
    task automatic home_run(string name, logic signed [7:0] m, logic [2:0] exp, logic [31:0] hm);
        logic [2:0] got;
        int n;
        got = 3'h0; idxSeen = 0;
        @(negedge ref_clk);
        homingMethod = m; homingStart = 1'b1;
        for (n = 0; n < 400 && got == 3'h0; n++) begin
            @(posedge ref_clk); #1;
            got = {homingDone, homingError, methodRefused};
            idxSeen |= int'(idxOut);
            @(negedge ref_clk); homingStart = 1'b0;
        end
        check({name, " outcome"}, 32'(exp), 32'(got));
        if (got == 3'h0) wrap_up();
        if (got[2]) check({name, " home"}, (hm === 32'hffffffff) ? loadPosition : hm,
                          homePosition);
        if (got[2] | got[1]) begin
            @(negedge ref_clk);
            homingStart = 1'b1;
            @(negedge ref_clk);
            homingStart = 1'b0;
        end
        run = 1'b0;
        $display("test %s finished", name);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (6) @(negedge ref_clk);
        arst_n = 1'b1;
        place(32'ha, 1'b0, 1'b1);
        home_run("idx34", lseh_pkg::METHOD_IDX_FWD, 3'h4, 32'h19);
        check("index echo", 32'h1, 32'(idxSeen));
        place(32'h28, 1'b1, 1'b1);
        home_run("idx33", lseh_pkg::METHOD_IDX_REV, 3'h4, 32'h19);
        ctrlVar = 1'b1; encoderType = lseh_pkg::ENC_ROTARY;
        place(32'ha, 1'b0, 1'b1);
        home_run("rotary", lseh_pkg::METHOD_IDX_FWD, 3'h4, 32'h19);
        check("index muted", 32'h0, 32'(idxSeen));
        ctrlVar = 1'b0; encoderType = lseh_pkg::ENC_INC_LINEAR;
        place(32'ha, 1'b0, 1'b0);
        home_run("dog_inc", lseh_pkg::METHOD_DOG, 3'h4, 32'h39);
        encoderType = lseh_pkg::ENC_ABS_LINEAR;
        place(32'ha, 1'b0, 1'b0);
        home_run("dog_abs", lseh_pkg::METHOD_DOG, 3'h4, 32'h35);
        encoderType = lseh_pkg::ENC_INC_LINEAR;
        place(32'h19, 1'b0, 1'b0);
        home_run("dog_nomark", lseh_pkg::METHOD_DOG, 3'h2, 32'h0);
        for (int i = 0; i < 4; i++) begin
            softLim = sl[i]; markPresent = mk[i];
            home_run("refuse", meth[i], 3'h1, 32'h0);
        end
        softLim = 1'b0; markPresent = 1'b1;
        place(32'ha, 1'b0, 1'b0);
        home_run("stroke11", lseh_pkg::METHOD_STROKE_F, 3'h4, 32'h19);
        place(32'h28, 1'b1, 1'b0);
        home_run("stroke43", lseh_pkg::METHOD_STROKE_R, 3'h4, 32'h19);
        arst_n = 1'b0;
        @(negedge ref_clk);
        arst_n = 1'b1;
        home_run("dset_early", lseh_pkg::METHOD_DATA_SET, 3'h1, 32'h0);
        condSel = 1'b1;
        home_run("dset_sel", lseh_pkg::METHOD_DATA_SET, 3'h4, 32'hffffffff);
        wrap_up();
    end
endmodule
